//--- hw/qpr_regen.sv
// Quadrature pulse regenerator with Avalon-MM configuration registers.
//
// Behaviour
// (RL1) Output configured pulses per revolution per channel.
// (RL2) Nonzero denominator scales by ppr over denominator.
// (RL3) Encoder, zero denominator: exact ppr, capped.
// (RL4) Scale source, zero denominator: one-to-one.
// (RL5) Fractional output never finer than encoder.
// (RL6) Decode source and B-phase logic codes 0-3.
// (RL7) Inverted B reverses B/A phase relation.
// (RL8) Encoder forced unless scale control mode active.
// (RL9) Host picks scale codes only when allowed.
// (RL10) Terminal select: regen pulses or compare output.
// (RL11) Parallel scale: forward or regenerate A/B.
// (RL12) Enabled limit detection raises fault 28.0.
// (RL13) Fault on output limit, not max frequency.
// (RL14) Correct output only up to 4 Mpps.
// (RL15) Polarity latched at power-on only.
// (RL16) No index phase output.
// (RL17) Gray-code A/B advance per scaled count.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module qpr_regen
    import qpr_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Avalon-MM slave.
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [1:0] AVS_RESPONSE,
    // Position sources: one-cycle count strobes with direction, and the scale A/B phases.
    input wire logic ENC_STEP,
    input wire logic ENC_DIR,
    input wire logic SCALE_STEP,
    input wire logic SCALE_DIR,
    input wire logic SCALE_A,
    input wire logic SCALE_B,
    // Control mode, power-on polarity and compare A/B inputs.
    input wire logic FULL_CLOSED,
    input wire logic SEMI_SCALE_MON,
    input wire logic POLARITY_IN,
    input wire logic COMPARE_A,
    input wire logic COMPARE_B,
    // Outputs.
    output logic PHASE_A_OUT,
    output logic PHASE_B_OUT,
    output logic REGEN_LIMIT_FAULT,
    output logic IRQ
);

    logic [PPR_W-1:0] ppr_q;
    logic [DEN_W-1:0] den_q;
    logic [DEN_W-1:0] encres_q;
    qpr_cfg_t cfg_q;
    logic pol_q, pol_taken_q;
    logic [1:0] irq_st_q, irq_mask_q;
    logic [ACC_W-1:0] acc_q;
    logic [3:0] backlog_q;
    logic backlog_dir_q;
    logic [4:0] gap_q;
    logic [1:0] gray_q;
    logic fault_q;
    qpr_state_t state_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic a_q, b_q;
    logic wait_q;
    logic irq_q;
    qpr_cfg_t cfg_wd;

    // Bus decode. A request is taken while no answer is pending and is
    // answered one cycle later. A write lands only on the answer edge,
    // the one edge at which the master counts the transfer as done.
    wire req = (AVS_READ | AVS_WRITE) & ~ack_q;
    wire wr = AVS_WRITE & ack_q;
    wire hit_ppr = AVS_ADDRESS == REG_PPR;
    wire hit_den = AVS_ADDRESS == REG_DEN;
    wire hit_ctrl = AVS_ADDRESS == REG_CTRL;
    wire hit_res = AVS_ADDRESS == REG_ENCRES;
    wire hit_stat = AVS_ADDRESS == REG_STAT;
    wire hit_ist = AVS_ADDRESS == REG_IRQ_ST;
    wire hit_msk = AVS_ADDRESS == REG_IRQ_MASK;
    wire mapped = hit_ppr | hit_den | hit_ctrl | hit_res | hit_stat |
        hit_ist | hit_msk;
    wire wr_all = wr & (&AVS_BYTEENABLE);
    wire [PPR_W-1:0] wd_ppr = AVS_WRITEDATA[PPR_W-1:0];
    wire [DEN_W-1:0] wd_den = AVS_WRITEDATA[DEN_W-1:0];
    // Out-of-range settings are refused so the ratio always stays defined.
    wire ppr_ok = wd_ppr >= PPR_MIN && wd_ppr <= PPR_MAX;
    wire den_ok = wd_den <= DEN_MAX;
    wire res_ok = wd_den != '0;

    // Control fields are picked by bit position, because the member order
    // of the struct differs from the bit order of the register.
    assign cfg_wd = {AVS_WRITEDATA[CTRL_SRC_LSB+1:CTRL_SRC_LSB],
        AVS_WRITEDATA[CTRL_OSEL],
        AVS_WRITEDATA[CTRL_PASS],
        AVS_WRITEDATA[CTRL_LIMEN]};

    // Readback words, laid out like the write side of each register.
    wire [31:0] ctrl_word = 32'({pol_q,
        cfg_q.regen_limit_detect_enable,
        cfg_q.scale_passthrough_select,
        cfg_q.output_terminal_select,
        cfg_q.b_logic_source_select});
    wire [31:0] stat_word = {FAULT_CODE & {16{fault_q}}, 8'h00,
        5'(state_q), gray_q, fault_q};
    wire [31:0] rd_mux =
        hit_ppr ? 32'(ppr_q) :
        hit_den ? 32'(den_q) :
        hit_ctrl ? ctrl_word :
        hit_res ? 32'(encres_q) :
        hit_stat ? stat_word :
        hit_ist ? 32'(irq_st_q) :
        hit_msk ? 32'(irq_mask_q) : UNMAPPED_VAL;

    // Source choice; scale only when a scale control mode is active.
    wire scale_ok = FULL_CLOSED | SEMI_SCALE_MON; // see (RL8) (RL9)
    wire use_scale = scale_ok & cfg_q.b_logic_source_select[1]; // see (RL6)
    wire b_inv = cfg_q.b_logic_source_select[0]; // see (RL6)
    wire passthru = use_scale & ~cfg_q.scale_passthrough_select; // see (RL11)
    // Power-on polarity flips the counting direction of the source.
    wire src_step = use_scale ? SCALE_STEP : ENC_STEP;
    wire src_dir = (use_scale ? SCALE_DIR : ENC_DIR) ^ pol_q; // see (RL15)

    // Ratio selection. Encoder with zero denominator: ppr over encoder
    // resolution; scale with zero denominator: 1:1; else ppr over den.
    wire den_zero = den_q == '0;
    wire [ACC_W-1:0] num_raw = den_zero ?
        (use_scale ? ACC_W'(1) : ACC_W'(ppr_q)) :
        ACC_W'(ppr_q); // see (RL1) (RL2) (RL3) (RL4)
    wire [ACC_W-1:0] den_sel = den_zero ?
        (use_scale ? ACC_W'(1) : ACC_W'(encres_q)) :
        ACC_W'(den_q); // see (RL2)
    // A ratio above one would create pulses finer than the source.
    wire [ACC_W-1:0] num_sel = (num_raw > den_sel) ?
        den_sel : num_raw; // see (RL3) (RL5)

    // Accumulator: reaching or passing the denominator yields one output count.
    wire [ACC_W:0] acc_sum = {1'b0, acc_q} + {1'b0, num_sel};
    wire acc_ovf = src_step & (acc_sum >= {1'b0, den_sel}); // see (RL2)
    wire [ACC_W-1:0] acc_d = !src_step ? acc_q :
        acc_ovf ? ACC_W'(acc_sum - {1'b0, den_sel}) : acc_sum[ACC_W-1:0];
    wire scaled = acc_ovf & ~passthru;
    wire sdir = src_dir;

    // Backlog of counts waiting for the 4 Mpps output spacing.
    wire can_emit = (gap_q == '0) && (backlog_q != '0);
    wire same_dir = backlog_q == '0 || backlog_dir_q == sdir;
    wire cancel = scaled & ~same_dir;
    wire add = scaled & same_dir;
    wire limit_hit = add & (backlog_q == BACKLOG_MAX) & ~can_emit;
    // A count that meets a full backlog is dropped whether or not the
    // fault is enabled; the host then loses position, which is what the
    // fault is there to report.
    wire backlog_inc = add & ~can_emit & ~limit_hit;
    wire backlog_dec = cancel | (~add & can_emit);
    wire [3:0] backlog_d = backlog_inc ? backlog_q + 4'h1 :
        backlog_dec ? backlog_q - 4'h1 : backlog_q;
    wire fault_set = limit_hit &
        cfg_q.regen_limit_detect_enable; // see (RL12) (RL13)
    wire [1:0] gray_next = backlog_dir_q ?
        {gray_q[0], ~gray_q[1]} : {~gray_q[0], gray_q[1]}; // see (RL17)
    wire emit = can_emit & ~cancel;

    // Terminal mux; index phase is never produced.
    wire regen_b = gray_q[0] ^ b_inv; // see (RL7) (RL16)
    wire a_d = cfg_q.output_terminal_select ? COMPARE_A :
        passthru ? SCALE_A : gray_q[1]; // see (RL10) (RL11)
    wire b_d = cfg_q.output_terminal_select ? COMPARE_B :
        passthru ? SCALE_B ^ b_inv : regen_b; // see (RL10) (RL7)
    wire [1:0] ev = {fault_set, emit};
    wire [1:0] w1c = (wr_all & hit_ist) ? AVS_WRITEDATA[1:0] : 2'h0;
    wire [1:0] irq_st_d = (irq_st_q & ~w1c) | ev;
    wire [1:0] irq_mask_d = (wr_all & hit_msk) ? AVS_WRITEDATA[1:0] :
        irq_mask_q;
    // The interrupt is built from next-state values, so the flop on the
    // pin adds no cycle of delay behind status and mask.
    wire irq_d = |(irq_st_d & irq_mask_d);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ppr_q <= PPR_RST;
            den_q <= '0;
            encres_q <= ENC_RES_RST;
            cfg_q <= '0;
            irq_mask_q <= '0;
        end else if (wr_all) begin
            if (hit_ppr && ppr_ok) ppr_q <= wd_ppr;
            if (hit_den && den_ok) den_q <= wd_den;
            if (hit_res && res_ok) encres_q <= wd_den;
            if (hit_ctrl) cfg_q <= cfg_wd;
            if (hit_msk) irq_mask_q <= AVS_WRITEDATA[1:0];
        end
    end

    // Polarity caught once after reset release, then frozen.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pol_q <= 1'b0;
            pol_taken_q <= 1'b0;
        end else if (!pol_taken_q) begin
            pol_q <= POLARITY_IN; // see (RL15)
            pol_taken_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            acc_q <= '0;
            backlog_q <= '0;
            backlog_dir_q <= 1'b0;
            gap_q <= '0;
            gray_q <= '0;
        end else begin
            acc_q <= acc_d;
            backlog_q <= backlog_d;
            if (add && backlog_q == '0) backlog_dir_q <= sdir;
            gap_q <= emit ? STEP_CYC - 5'h1 :
                (gap_q != '0 ? gap_q - 5'h1 : gap_q); // see (RL14)
            if (emit) gray_q <= gray_next;
        end
    end

    // Fault is sticky until reset; status bits are write-one-to-clear
    // and a simultaneous event wins over the clear.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fault_q <= 1'b0;
            state_q <= ST_IDLE;
            irq_st_q <= '0;
        end else begin
            if (fault_set) fault_q <= 1'b1; // see (RL12)
            irq_st_q <= irq_st_d;
            unique case (state_q)
                ST_IDLE: begin
                    if (fault_set) state_q <= ST_FAULT;
                    else if (backlog_q != '0) state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (fault_set) state_q <= ST_FAULT;
                    else if (backlog_q == '0) state_q <= ST_IDLE;
                end
                ST_FAULT: state_q <= ST_FAULT;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            resp_q <= 2'h0;
            a_q <= 1'b0;
            b_q <= 1'b0;
            wait_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            ack_q <= req;
            wait_q <= ~req;
            irq_q <= irq_d;
            rdata_q <= rd_mux;
            resp_q <= mapped ? 2'h0 : 2'h2;
            a_q <= a_d;
            b_q <= b_d;
        end
    end

    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;
    assign AVS_RESPONSE = resp_q;
    assign PHASE_A_OUT = a_q;
    assign PHASE_B_OUT = b_q;
    assign REGEN_LIMIT_FAULT = fault_q;
    assign IRQ = irq_q;

endmodule : qpr_regen

//--- hw/qpr_pkg.sv
// Package with constants and carrier types for the quadrature regenerator.
package qpr_pkg;

    localparam int PPR_W = 22;
    localparam int DEN_W = 24;
    localparam int ACC_W = 26;
    localparam logic [PPR_W-1:0] PPR_MIN = 22'h000001;
    localparam logic [PPR_W-1:0] PPR_MAX = 22'h200000;
    localparam logic [DEN_W-1:0] DEN_MAX = 24'h800000;
    localparam logic [PPR_W-1:0] PPR_RST = 22'h000400;
    localparam logic [DEN_W-1:0] ENC_RES_RST = 24'h000400;

    // Output rate limit: 4 Mpps after four-times count at 100 MHz clock.
    localparam int CLK_HZ = 100000000;
    localparam int MAX_PPS = 4000000;
    localparam int MIN_STEP_CYC = (CLK_HZ + MAX_PPS - 1) / MAX_PPS;
    localparam logic [4:0] STEP_CYC = 5'(MIN_STEP_CYC);
    localparam logic [3:0] BACKLOG_MAX = 4'hF;

    localparam logic [1:0] SRC_ENC_NORM = 2'h0;
    localparam logic [1:0] SRC_ENC_INV = 2'h1;
    localparam logic [1:0] SRC_EXT_NORM = 2'h2;
    localparam logic [1:0] SRC_EXT_INV = 2'h3;

    localparam logic [15:0] FAULT_CODE = 16'h0280;

    // Avalon-MM register byte addresses.
    localparam logic [5:0] REG_PPR = 6'h00;
    localparam logic [5:0] REG_DEN = 6'h04;
    localparam logic [5:0] REG_CTRL = 6'h08;
    localparam logic [5:0] REG_ENCRES = 6'h0C;
    localparam logic [5:0] REG_STAT = 6'h10;
    localparam logic [5:0] REG_IRQ_ST = 6'h14;
    localparam logic [5:0] REG_IRQ_MASK = 6'h18;
    localparam logic [31:0] UNMAPPED_VAL = 32'hDEADBEEF;

    // Bit positions of the control register.
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_OSEL = 2;
    localparam int CTRL_PASS = 3;
    localparam int CTRL_LIMEN = 4;
    localparam int CTRL_POL = 5;

    typedef struct packed {
        logic [1:0] b_logic_source_select;
        logic output_terminal_select;
        logic scale_passthrough_select;
        logic regen_limit_detect_enable;
    } qpr_cfg_t;

    typedef struct packed {
        logic step;
        logic dir;
    } qpr_step_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b100
    } qpr_state_t;

endpackage : qpr_pkg

//--- dv/qpr_chk.sv
// Port checker for the quadrature regenerator.
`timescale 1ns/1ps
module qpr_chk
    import qpr_pkg::*;
(
    // Clock, reset and bus.
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [1:0] AVS_RESPONSE,
    // Regenerated outputs.
    input wire logic PHASE_A_OUT,
    input wire logic PHASE_B_OUT,
    input wire logic REGEN_LIMIT_FAULT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire req = AVS_READ || AVS_WRITE;
    logic [4:0] gap_q;
    // Cycles since the last phase edge, saturating so idle time is safe.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gap_q <= 5'h1F;
        end else if ($changed(PHASE_A_OUT) || $changed(PHASE_B_OUT)) begin
            gap_q <= 5'h00;
        end else if (gap_q != 5'h1F) begin
            gap_q <= gap_q + 5'h01;
        end
    end
    AST_ONE_CYCLE: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered after one cycle");
    AST_ANS_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    AST_NO_SPUR: assert property (!AVS_WAITREQUEST |-> $past(req))
        else $error("answer without a request");
    AST_UNMAP: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS > REG_IRQ_MASK |-> AVS_RESPONSE == 2'h2
        && AVS_READDATA == UNMAPPED_VAL)
        else $error("unmapped read answered wrongly");
    AST_MAPPED: assert property (AVS_READ && !AVS_WAITREQUEST
        && AVS_ADDRESS == REG_PPR |-> AVS_RESPONSE == 2'h0)
        else $error("mapped read not answered ok");
    AST_RST_VAL: assert property ($fell(SYS_RST) |-> !PHASE_A_OUT
        && !PHASE_B_OUT && !REGEN_LIMIT_FAULT && AVS_WAITREQUEST)
        else $error("outputs not at reset values");
    AST_GRAY: assert property ($changed(PHASE_A_OUT) |-> $stable(PHASE_B_OUT))
        else $error("both phases moved in one cycle");
    AST_RATE: assert property ($changed(PHASE_A_OUT) || $changed(PHASE_B_OUT)
        |-> gap_q >= STEP_CYC - 5'h01)
        else $error("phase edges closer than the rate limit");
    AST_FAULT_HOLD: assert property (REGEN_LIMIT_FAULT |=> REGEN_LIMIT_FAULT)
        else $error("limit fault dropped before reset");
    cover property (REGEN_LIMIT_FAULT);
    cover property ($changed(PHASE_B_OUT));
    cover property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == REG_STAT);
endmodule : qpr_chk

//--- dv/qpr_host.sv
// Host controller model that counts the regenerated quadrature phases.
`timescale 1ns/1ps
module qpr_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Quadrature phases and position count.
    input wire logic a,
    input wire logic b,
    output int count
);
    logic a_q;
    logic b_q;
    // Every edge of either phase moves one position: four-times count.
    always_ff @(posedge clk) begin
        a_q <= a;
        b_q <= b;
        if (rst) begin
            count <= 0;
        end else if ((a != a_q) || (b != b_q)) begin
            count <= count + ((a_q ^ b) ? -1 : 1);
        end
    end
endmodule : qpr_host

//--- dv/tb.sv
// Self-checking testbench for the quadrature regenerator.
`timescale 1ns/1ps
module tb
    import qpr_pkg::*;
;
    logic CLK = 1'h0, SYS_RST = 1'h1, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
    logic [5:0] AVS_ADDRESS = 6'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rdat;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic ENC_STEP = 1'h0, ENC_DIR = 1'h0, SCALE_STEP = 1'h0;
    logic SCALE_DIR = 1'h0, SCALE_A = 1'h0, SCALE_B = 1'h0;
    logic FULL_CLOSED = 1'h1, SEMI_SCALE_MON = 1'h0, POLARITY_IN = 1'h0;
    logic COMPARE_A = 1'h0, COMPARE_B = 1'h0, AVS_WAITREQUEST, IRQ;
    logic PHASE_A_OUT, PHASE_B_OUT, REGEN_LIMIT_FAULT;
    logic [1:0] AVS_RESPONSE;
    logic [5:0] ra[5] = '{REG_PPR, REG_DEN, REG_CTRL, REG_ENCRES, 6'h20};
    logic [31:0] rv[5] = '{32'h400, 32'h0, 32'h0, 32'h400, UNMAPPED_VAL};
    int pos, base, e, bad_count = 0, check_count = 0;
    always #5 CLK = ~CLK;
    qpr_regen dut_u (.CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
        .AVS_RESPONSE, .ENC_STEP, .ENC_DIR, .SCALE_STEP, .SCALE_DIR,
        .SCALE_A, .SCALE_B, .FULL_CLOSED, .SEMI_SCALE_MON, .POLARITY_IN,
        .COMPARE_A, .COMPARE_B, .PHASE_A_OUT, .PHASE_B_OUT,
        .REGEN_LIMIT_FAULT, .IRQ);
    qpr_host host_u (.clk(CLK), .rst(SYS_RST), .a(PHASE_A_OUT),
        .b(PHASE_B_OUT), .count(pos));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Entered just after an edge; holds the request until answered.
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'h0);
        rdat = AVS_READDATA;
        AVS_WRITE <= 1'h0;
        AVS_READ <= 1'h0;
        @(posedge CLK);
    endtask : bus
    task automatic steps(input logic sc, input logic dr, input int n,
        input int gap);
        repeat (n) begin
            ENC_STEP <= !sc;
            SCALE_STEP <= sc;
            ENC_DIR <= dr;
            SCALE_DIR <= dr;
            @(posedge CLK);
            ENC_STEP <= 1'h0;
            SCALE_STEP <= 1'h0;
            repeat (gap - 1) @(posedge CLK);
        end
        repeat (500) @(posedge CLK);
    endtask : steps
    task automatic moved(input int want);
        chk(32'(pos - base), 32'(want));
    endtask : moved
    task automatic wait_chk(input logic got_now, input logic exp);
        repeat (3) @(posedge CLK);
        chk(32'(got_now), 32'(exp));
    endtask : wait_chk
    initial begin
        repeat (3) @(posedge CLK);
        SYS_RST <= 1'h0;
        @(posedge CLK);
        POLARITY_IN <= 1'h1;
        foreach (ra[i]) begin
            bus(1'h0, ra[i], 32'h0);
            chk(rdat, rv[i]);
        end
        bus(1'h1, REG_CTRL, 32'h04);
        COMPARE_B <= 1'h1;
        repeat (3) @(posedge CLK);
        chk(32'(PHASE_B_OUT), 32'h1);
        repeat (30) @(posedge CLK);
        COMPARE_B <= 1'h0;
        repeat (30) @(posedge CLK);
        bus(1'h1, REG_CTRL, 32'h0A);
        SCALE_A <= 1'h1;
        repeat (3) @(posedge CLK);
        chk(32'(PHASE_A_OUT), 32'h0);
        bus(1'h1, REG_CTRL, 32'h02);
        repeat (3) @(posedge CLK);
        chk(32'(PHASE_A_OUT), 32'h1);
        repeat (30) @(posedge CLK);
        SCALE_A <= 1'h0;
        repeat (30) @(posedge CLK);
        bus(1'h1, REG_PPR, 32'h200);
        for (int c = 0; c < 4; c++) begin
            bus(1'h1, REG_CTRL, 32'(c) | 32'h08);
            // Let a B edge from an inversion change reach the host first.
            repeat (30) @(posedge CLK);
            base = pos;
            e = c[1] ? 4 : 2;
            steps(c[1], 1'h0, 4, 30);
            moved(c[0] ? -e : e);
        end
        bus(1'h1, REG_CTRL, 32'h02);
        FULL_CLOSED <= 1'h0;
        repeat (30) @(posedge CLK);
        base = pos;
        steps(1'h1, 1'h0, 4, 30);
        steps(1'h0, 1'h1, 4, 30);
        moved(-2);
        bus(1'h1, REG_CTRL, 32'h0);
        bus(1'h1, REG_PPR, 32'h3);
        bus(1'h1, REG_DEN, 32'h4);
        base = pos;
        steps(1'h0, 1'h0, 8, 30);
        moved(6);
        bus(1'h1, REG_PPR, 32'h8);
        base = pos;
        steps(1'h0, 1'h0, 4, 30);
        moved(4);
        chk(32'(IRQ), 32'h0);
        bus(1'h1, REG_IRQ_MASK, 32'h1);
        chk(32'(IRQ), 32'h1);
        bus(1'h1, REG_IRQ_ST, 32'h1);
        chk(32'(IRQ), 32'h0);
        bus(1'h1, REG_DEN, 32'h0);
        bus(1'h1, REG_PPR, 32'h400);
        steps(1'h0, 1'h0, 20, 2);
        chk(32'(REGEN_LIMIT_FAULT), 32'h0);
        bus(1'h1, REG_CTRL, 32'h10);
        steps(1'h0, 1'h0, 20, 2);
        chk(32'(REGEN_LIMIT_FAULT), 32'h1);
        bus(1'h0, REG_STAT, 32'h0);
        chk({rdat[31:16], 15'h0, rdat[0]}, {FAULT_CODE, 16'h1});
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge CLK);
        bad_count++;
        report_and_stop();
    end
endmodule : tb
bind qpr_regen qpr_chk chk_u (.CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE,
    .PHASE_A_OUT, .PHASE_B_OUT, .REGEN_LIMIT_FAULT);
